/* File: rtl/mrt_timer_ui.sv */
// Front-panel control, interval timing and hour counter of the relay timer.
`timescale 1ns/1ps
`default_nettype none
module mrt_timer_ui #(
    parameter int TICK_CYCLES = mrt_pkg::TICK_CYC
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic master_rst_in,
    input wire mrt_pkg::mrt_btn_s btn_in,
    input wire logic start_in,
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic relay_out,
    output logic relay_led_out,
    output mrt_pkg::mrt_disp_s disp_out
);
    import mrt_pkg::*;

    logic mrst;
    logic [22:0] div;
    logic tick;
    logic [3:0] bq;
    logic [3:0] pr;
    logic [7:0] mode_hold;
    logic [7:0] ok_hold;
    logic mode_fire;
    logic ok_fire;
    mrt_state_e st;
    mrt_state_e st_q;
    logic [7:0] tmr;
    logic [3:0] func;
    mrt_ivl_s ivl [2];
    logic idx;
    logic fchg;
    logic programmed;
    logic use2;
    logic use_st;
    logic start_q;
    logic run_en;
    logic active;
    logic phase;
    logic done;
    logic [12:0] rem;
    logic [15:0] sub;
    mrt_ivl_s cur;
    logic [15:0] on_tk;
    logic [6:0] hrs_lo;
    logic [13:0] hrs_hi;
    logic [7:0] alt_tk;
    logic show2;
    logic same;
    mrt_disp_s next_disp;

    // The hidden reset restarts control but leaves settings alone.
    assign mrst = srst_in | master_rst_in; // RULE22
    assign use2 = T2_MASK[func];
    assign use_st = START_MASK[func];
    assign same = (ivl[0] == ivl[1]);
    assign cur = ivl[phase];
    assign pr = btn_in & ~bq;

    always_ff @(posedge mclk_in) begin
        if (mrst || div == 23'(TICK_CYCLES - 1)) begin
            div <= '0;
        end else begin
            div <= div + 23'h000001;
        end
        tick <= !mrst && div == 23'(TICK_CYCLES - 1); // RULE23
    end

    always_ff @(posedge mclk_in) begin
        if (mrst) begin
            bq <= 4'hF;
            start_q <= 1'b0;
        end else begin
            bq <= btn_in;
            start_q <= start_in;
        end
    end

    // Hold counters saturate so a held button fires once per press.
    assign mode_fire = tick && btn_in.mode && mode_hold == HOLD_TK - 8'h01;
    assign ok_fire = tick && btn_in.ok && ok_hold == HOLD_TK - 8'h01;

    always_ff @(posedge mclk_in) begin
        if (mrst || !btn_in.mode) begin
            mode_hold <= '0;
        end else if (tick && mode_hold != HOLD_TK) begin
            mode_hold <= mode_hold + 8'h01;
        end
        if (mrst || !btn_in.ok) begin
            ok_hold <= '0;
        end else if (tick && ok_hold != HOLD_TK) begin
            ok_hold <= ok_hold + 8'h01;
        end
    end

    always_ff @(posedge mclk_in) begin
        st_q <= st;
        if (mrst || st != st_q) begin
            tmr <= '0;
        end else if (tick) begin
            tmr <= tmr + 8'h01;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            st <= ST_TEST; // RULE2
            func <= FUNC_FIRST;
            ivl[0] <= IVL_RST;
            ivl[1] <= IVL_RST;
            programmed <= 1'b0;
            idx <= 1'b0;
            fchg <= 1'b0;
        end else if (master_rst_in) begin
            st <= ST_TEST; // RULE22
            idx <= 1'b0;
        end else begin
            unique case (st)
                ST_TEST: begin
                    if (tick && tmr == TEST_TK - 8'h01) begin
                        st <= programmed ? ST_RUN : ST_FSEL; // RULE2
                    end
                end
                ST_FSEL: begin
                    if (pr[3]) begin
                        func <= (func == FUNC_LAST) ? FUNC_FIRST
                                : func + 4'h1; // RULE1 RULE3
                        fchg <= 1'b1;
                    end else if (pr[2]) begin
                        func <= (func == FUNC_FIRST) ? FUNC_LAST
                                : func - 4'h1; // RULE1 RULE3
                        fchg <= 1'b1;
                    end else if (pr[1]) begin
                        st <= ST_RSEL; // RULE5
                        idx <= 1'b0;
                        if (fchg) begin
                            ivl[0] <= IVL_RST; // RULE12
                            ivl[1] <= IVL_RST;
                        end
                    end
                end
                ST_RSEL: begin
                    if (pr[0]) begin
                        ivl[idx].scale <= (ivl[idx].scale == SC_D) ? SC_H
                                : ivl[idx].scale + 3'h1; // RULE6
                        ivl[idx].val <= VAL_MIN;
                    end else if (pr[1]) begin
                        st <= ST_TSEL; // RULE7
                    end
                end
                ST_TSEL: begin
                    if (pr[3]) begin
                        if (ivl[idx].val < mrt_max(ivl[idx].scale)) begin
                            ivl[idx].val <= ivl[idx].val + 13'h0001; // RULE8
                        end
                    end else if (pr[2]) begin
                        if (ivl[idx].val > VAL_MIN) begin
                            ivl[idx].val <= ivl[idx].val - 13'h0001; // RULE8
                        end
                    end else if (pr[1]) begin
                        if (!idx && use2) begin
                            st <= ST_T2ASK; // RULE9
                        end else begin
                            st <= ST_RUN; // RULE8 RULE10
                            programmed <= 1'b1;
                        end
                    end
                end
                ST_T2ASK: begin
                    if (pr[1]) begin
                        ivl[1] <= ivl[0]; // RULE9
                        st <= ST_RUN;
                        programmed <= 1'b1;
                    end else if (pr[0]) begin
                        idx <= 1'b1; // RULE10
                        st <= ST_RSEL;
                    end
                end
                ST_RUN: begin
                    if (mode_fire) begin
                        st <= ST_FSEL; // RULE11
                        fchg <= 1'b0;
                    end else if (ok_fire) begin
                        st <= ST_HOURS; // RULE18
                    end
                end
                ST_HOURS: begin
                    if (mode_fire) begin
                        st <= ST_FSEL; // RULE11
                        fchg <= 1'b0;
                    end else if (ok_fire) begin
                        st <= ST_RUN; // RULE21
                    end else if (tick && tmr == SHOW_TK - 8'h01) begin
                        st <= ST_RUN; // RULE20
                    end
                end
            endcase
        end
    end

    // Timing runs only in normal operation; leaving it aborts the cycle.
    always_ff @(posedge mclk_in) begin
        if (mrst || !(st inside {ST_RUN, ST_HOURS})) begin
            active <= 1'b0; // RULE13
            relay_out <= 1'b0;
            relay_led_out <= 1'b0;
            phase <= 1'b0;
            done <= 1'b0;
            rem <= '0;
            sub <= '0;
        end else if (run_en && !active
                && (use_st ? (start_in && !start_q) : !done)) begin
            active <= 1'b1; // RULE1
            phase <= 1'b0;
            rem <= ivl[0].val;
            sub <= '0;
            relay_out <= 1'b1;
            relay_led_out <= 1'b1; // RULE17
        end else if (active && tick) begin
            if (sub == mrt_unit(cur.scale) - 16'h0001) begin
                sub <= '0;
                if (rem != 13'h0001) begin
                    rem <= rem - 13'h0001; // RULE23
                end else if (!phase && use2) begin
                    phase <= 1'b1;
                    rem <= ivl[1].val;
                    relay_out <= 1'b0;
                    relay_led_out <= 1'b0; // RULE17
                end else begin
                    active <= 1'b0;
                    done <= 1'b1;
                    relay_out <= 1'b0;
                    relay_led_out <= 1'b0; // RULE17
                end
            end else begin
                sub <= sub + 16'h0001;
            end
        end
    end

    // Hours are kept as hundreds and remainder so division is free.
    always_ff @(posedge mclk_in) begin
        if (srst_in || (st == ST_HOURS && ok_fire)) begin
            on_tk <= '0; // RULE21
            hrs_lo <= '0;
            hrs_hi <= '0;
        end else if (relay_out && tick) begin
            if (on_tk == HOUR_TK - 16'h0001) begin
                on_tk <= '0; // RULE18
                if (hrs_lo == LO_MAX) begin
                    hrs_lo <= '0;
                    if (hrs_hi != HI_MAX) begin
                        hrs_hi <= hrs_hi + 14'h0001;
                    end
                end else begin
                    hrs_lo <= hrs_lo + 7'h01;
                end
            end else begin
                on_tk <= on_tk + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (mrst || st != ST_RUN || active || !use2 || same) begin
            alt_tk <= '0;
            show2 <= 1'b0;
        end else if (tick) begin
            if (alt_tk == ALT_TK - 8'h01) begin
                alt_tk <= '0;
                show2 <= !show2; // RULE15
            end else begin
                alt_tk <= alt_tk + 8'h01;
            end
        end
    end

    always_comb begin
        next_disp = '0;
        next_disp.func = func;
        next_disp.start_sym = use_st; // RULE4 RULE14
        next_disp.start_lvl = use_st && start_q;
        next_disp.t1_ind = 1'b1;
        next_disp.t2_ind = use2; // RULE4
        next_disp.scale = ivl[idx].scale;
        next_disp.value = 14'(ivl[idx].val);
        unique case (st)
            ST_TEST: begin
                next_disp = '1;
                next_disp.value = TEST_VAL;
                next_disp.scale = SC_H;
            end
            ST_FSEL: begin
                next_disp.func_flash = 1'b1; // RULE2
            end
            ST_RSEL, ST_TSEL: begin
                next_disp.scale_flash = (st == ST_RSEL); // RULE5
                next_disp.digit_flash = (st == ST_TSEL); // RULE7
                next_disp.t1_ind = !idx;
                next_disp.t2_ind = idx;
            end
            ST_T2ASK: begin
                next_disp.t1_ind = 1'b0;
                next_disp.t2_ind = 1'b1; // RULE9
            end
            ST_RUN: begin
                if (active) begin
                    next_disp.func_flash = 1'b1; // RULE16
                    next_disp.dp_flash = 1'b1;
                    next_disp.clock_sym = 1'b1;
                    next_disp.t1_ind = !phase;
                    next_disp.t2_ind = phase;
                    next_disp.scale = cur.scale;
                    next_disp.value = 14'(rem);
                end else begin
                    next_disp.t1_ind = !show2 || (use2 && same); // RULE15
                    next_disp.t2_ind = use2 && (same || show2);
                    next_disp.scale = ivl[show2].scale; // RULE14
                    next_disp.value = 14'(ivl[show2].val);
                end
            end
            ST_HOURS: begin
                next_disp.t1_ind = 1'b0;
                next_disp.t2_ind = 1'b0;
                next_disp.scale = SC_H;
                next_disp.hundredfold_scale_indicator_ind = (hrs_hi >= HUNDREDFOLD_SCALE_INDICATOR_AT); // RULE19
                next_disp.value = (hrs_hi >= HUNDREDFOLD_SCALE_INDICATOR_AT) ? hrs_hi
                        : 14'(hrs_hi * 14'h0064) + 14'(hrs_lo);
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (mrst) begin
            disp_out <= '0;
        end else begin
            disp_out <= next_disp;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            run_en <= CTRL_RST;
        end else if (wr_in && addr_in == REG_CTRL) begin
            run_en <= wdata_in[0];
        end
        rdata_out <= '0;
        if (!srst_in && rd_in) begin
            unique case (addr_in)
                REG_CTRL: rdata_out <= {31'h0, run_en};
                REG_STAT: rdata_out <= {17'h0, func, relay_out,
                        phase, active, 1'b0, st};
                REG_HOURS: rdata_out <= {2'h0, hrs_hi, 9'h0, hrs_lo};
                default: rdata_out <= '0;
            endcase
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in || master_rst_in);

    sequence s_t1_done;
        st == ST_TSEL && pr[1] && !pr[3] && !pr[2] && !idx;
    endsequence
    sequence s_t2_copy;
        st == ST_T2ASK && pr[1];
    endsequence

    a_led_follow: assert property (relay_out == relay_led_out) // RULE17
        else $error("Relay LED does not match relay.");
    a_prog_drop: assert property ( // RULE13
        st == ST_FSEL |=> !relay_out && !active)
        else $error("Relay energised during programming.");
    a_func_legal: assert property ( // RULE1
        func >= FUNC_FIRST && func <= FUNC_LAST)
        else $error("Function number out of range.");
    a_fsel_ok: assert property ( // RULE5
        st == ST_FSEL && pr[1] && !pr[3] && !pr[2] |=> st == ST_RSEL
        ##1 disp_out.scale_flash)
        else $error("OK did not open range selection.");
    a_scale_wrap: assert property ( // RULE6
        st == ST_RSEL && pr[0] && ivl[idx].scale == SC_D
        |=> ivl[idx].scale == SC_H)
        else $error("Scale did not wrap to hours.");
    a_t2_offer: assert property ( // RULE9
        s_t1_done ##0 use2 |=> st == ST_T2ASK
        ##1 disp_out.t2_ind && disp_out.value == 14'(ivl[0].val))
        else $error("Second interval not offered.");
    a_t2_copy: assert property ( // RULE9
        s_t2_copy |=> st == ST_RUN && ivl[1] == ivl[0])
        else $error("Second interval not copied.");
    a_t1_only: assert property ( // RULE8
        s_t1_done ##0 !use2 |=> st == ST_RUN ##1 !disp_out.digit_flash)
        else $error("Single interval did not end programming.");
    a_mode_hold: assert property ( // RULE11
        st == ST_RUN && mode_fire |=> st == ST_FSEL)
        else $error("MODE hold did not re-enter programming.");
    a_hours_back: assert property ( // RULE20
        st == ST_HOURS && !ok_fire && !mode_fire && tick
        && tmr == SHOW_TK - 8'h01 |=> st == ST_RUN)
        else $error("Hour display did not time out.");
    a_hours_hundredfold_scale_indicator: assert property ( // RULE19
        st == ST_HOURS && hrs_hi >= HUNDREDFOLD_SCALE_INDICATOR_AT |=> disp_out.hundredfold_scale_indicator_ind
        && disp_out.value == $past(hrs_hi))
        else $error("Hundredfold display wrong.");
    a_alt_swap: assert property ( // RULE15
        st == ST_RUN && !active && use2 && !same && tick
        && alt_tk == ALT_TK - 8'h01 |=> show2 != $past(show2))
        else $error("Idle display did not alternate.");
endmodule : mrt_timer_ui
`default_nettype wire

/* File: common/mrt_pkg.sv */
// Constants, types and helper functions for the multifunction relay timer.
// Overview of operation
// RULE1: Fourteen functions: five supply, nine start input.
// RULE2: Power-up self-test, then function select, first code.
// RULE3: Plus and minus step the function.
// RULE4: Light interval and start symbols per function.
// RULE5: OK confirms function; range indicators flash.
// RULE6: MODE cycles seven scales with own limits.
// RULE7: OK confirms scale; four digits flash.
// RULE8: Plus/minus set first interval; OK confirms.
// RULE9: Second interval offered; OK copies first time.
// RULE10: MODE repeats range and time for second.
// RULE11: MODE held five seconds re-enters programming.
// RULE12: Changed function forces re-entry; else OK skips.
// RULE13: Programming aborts timing and drops relay.
// RULE14: Idle shows function, start status, first interval.
// RULE15: Differing intervals alternate; equal light both.
// RULE16: Triggered shows flashes, interval, clock, remaining.
// RULE17: Relay LED follows energised relay.
// RULE18: Accumulate relay hours; OK held shows total.
// RULE19: Above 9999 hours show hundredfold and divide.
// RULE20: Hour total returns to normal after ten seconds.
// RULE21: OK held again clears hour total.
// RULE22: Hidden reset restarts but keeps settings.
// RULE23: All timing from one tenth-second tick.
package mrt_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int TICKS_PER_S = 1000 / TICK_MS;
    localparam int HOLD_S = 5;
    localparam int ALT_S = 5;
    localparam int SHOW_S = 10;
    localparam logic [7:0] HOLD_TK = 8'(HOLD_S * TICKS_PER_S);
    localparam logic [7:0] ALT_TK = 8'(ALT_S * TICKS_PER_S);
    localparam logic [7:0] SHOW_TK = 8'(SHOW_S * TICKS_PER_S);
    localparam logic [7:0] TEST_TK = 8'h0A;
    localparam logic [15:0] HOUR_TK = 16'h8CA0;
    localparam logic [3:0] FUNC_FIRST = 4'h1;
    localparam logic [3:0] FUNC_LAST = 4'hE;
    localparam logic [14:0] T2_MASK = 15'h7C30;
    localparam logic [14:0] START_MASK = 15'h7FC0;
    localparam logic [2:0] SC_H = 3'h0;
    localparam logic [2:0] SC_HM = 3'h1;
    localparam logic [2:0] SC_M = 3'h2;
    localparam logic [2:0] SC_MS = 3'h3;
    localparam logic [2:0] SC_S = 3'h4;
    localparam logic [2:0] SC_SD = 3'h5;
    localparam logic [2:0] SC_D = 3'h6;
    localparam logic [12:0] VAL_MIN = 13'h0001;
    localparam logic [6:0] LO_MAX = 7'h63;
    localparam logic [13:0] HI_MAX = 14'h270F;
    localparam logic [13:0] HUNDREDFOLD_SCALE_INDICATOR_AT = 14'h0064;
    localparam logic [13:0] TEST_VAL = 14'h22B8;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h1;
    localparam logic [3:0] REG_HOURS = 4'h2;
    localparam logic CTRL_RST = 1'h1;

    typedef enum logic [6:0] {
        ST_TEST = 7'h01, ST_FSEL = 7'h02, ST_RSEL = 7'h04,
        ST_TSEL = 7'h08, ST_T2ASK = 7'h10, ST_RUN = 7'h20,
        ST_HOURS = 7'h40
    } mrt_state_e;

    typedef struct packed {
        logic plus;
        logic minus;
        logic ok;
        logic mode;
    } mrt_btn_s;

    typedef struct packed {
        logic [2:0] scale;
        logic [12:0] val;
    } mrt_ivl_s;

    localparam mrt_ivl_s IVL_RST = '{scale: SC_S, val: VAL_MIN};

    typedef struct packed {
        logic [3:0] func;
        logic func_flash;
        logic [13:0] value;
        logic digit_flash;
        logic [2:0] scale;
        logic scale_flash;
        logic t1_ind;
        logic t2_ind;
        logic start_sym;
        logic start_lvl;
        logic clock_sym;
        logic dp_flash;
        logic hundredfold_scale_indicator_ind;
    } mrt_disp_s;

    function automatic logic [15:0] mrt_unit(input logic [2:0] s);
        unique case (s)
            SC_H: mrt_unit = 16'h8CA0;
            SC_HM, SC_M: mrt_unit = 16'h0258;
            SC_MS, SC_S: mrt_unit = 16'h000A;
            default: mrt_unit = 16'h0001;
        endcase
    endfunction : mrt_unit

    function automatic logic [12:0] mrt_max(input logic [2:0] s);
        unique case (s)
            SC_H: mrt_max = 13'h0063;
            SC_HM: mrt_max = 13'h176F;
            SC_M, SC_S: mrt_max = 13'h003B;
            SC_MS: mrt_max = 13'h0E0F;
            SC_SD: mrt_max = 13'h0257;
            default: mrt_max = 13'h0009;
        endcase
    endfunction : mrt_max
endpackage : mrt_pkg

/* File: tb/mrt_panel_model.sv */
// Push-button panel that holds a commanded button pattern for a while.
`timescale 1ns/1ps
`default_nettype none
module mrt_panel_model (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire mrt_pkg::mrt_btn_s cmd_in,
    input wire logic [15:0] len_in,
    output var mrt_pkg::mrt_btn_s btn_out
);
    import mrt_pkg::*;
    logic [15:0] left;
    // Every press ends in a release, so the next press is a fresh edge.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            btn_out <= '0;
            left <= '0;
        end else if (cmd_in != '0) begin
            btn_out <= cmd_in;
            left <= len_in;
        end else if (left != '0) begin
            left <= left - 16'h0001;
        end else begin
            btn_out <= '0;
        end
    end
endmodule : mrt_panel_model
`default_nettype wire

/* File: tb/tb_multifunction_relay_timer_ui.sv */
// Self-checking bench for the relay timer front-panel control.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, a, b); end end
module tb_multifunction_relay_timer_ui;
    import mrt_pkg::*;
    localparam int TK = 4;
    localparam mrt_btn_s B_PLUS = 4'h8;
    localparam mrt_btn_s B_MINUS = 4'h4;
    localparam mrt_btn_s B_OK = 4'h2;
    localparam mrt_btn_s B_MODE = 4'h1;
    logic mclk_in = 0, srst_in = 1, mrst = 0, start = 0, wr = 0, rd = 0;
    logic [3:0] addr = '0;
    logic [31:0] wdata = '0, rdata, d, seed = 32'h0000F085;
    logic relay, led;
    logic [2:0] sc;
    logic [15:0] len = '0;
    mrt_btn_s cmd = '0, btn;
    mrt_disp_s disp;
    int failures = 0, n_tests = 0, cnt, f, m;

    mrt_timer_ui #(.TICK_CYCLES(TK)) mrt_timer_ui_inst (
        .mclk_in(mclk_in), .srst_in(srst_in), .master_rst_in(mrst),
        .btn_in(btn), .start_in(start), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .relay_out(relay),
        .relay_led_out(led), .disp_out(disp));
    mrt_panel_model mrt_panel_model_inst (.mclk_in(mclk_in),
        .srst_in(srst_in), .cmd_in(cmd), .len_in(len), .btn_out(btn));

    initial begin
        forever #10 mclk_in = ~mclk_in;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    function automatic logic [2:0] nsc(input logic [2:0] s);
        return (s == SC_D) ? SC_H : s + 3'h1;
    endfunction : nsc

    task automatic final_report;
        $display("tests=%0d failures=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk_in);
        #1;
    endtask : cyc

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk_in);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk_in);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a);
        @(posedge mclk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_in);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    // Start input wanders at random; of the functions run here, only function 10 uses it.
    task automatic push(input mrt_btn_s b, input int k);
        @(posedge mclk_in);
        seed = xs(seed);
        cmd <= b;
        len <= 16'(k);
        start <= seed[0];
        @(posedge mclk_in);
        cmd <= '0;
        cyc(k + 4);
    endtask : push

    task automatic wait_state(input logic [6:0] st, input int lim);
        for (cnt = 0; cnt < lim; cnt++) begin
            rd_reg(REG_STAT);
            if (d[6:0] === st) break;
        end
        if (cnt == lim) begin
            failures++;
            $display("MISMATCH t=%0t state wait", $time);
            final_report();
        end else begin
            cyc(2);
        end
    endtask : wait_state

    initial begin
        repeat (4) @(posedge mclk_in);
        srst_in <= 1'b0;
        rd_reg(REG_CTRL);
        `CHK(d[0], 1'b1)
        @(posedge mclk_in);
        #1 `CHK(rdata, 32'h0)
        rd_reg(4'hF);
        `CHK(d, 32'h0)
        wr_reg(4'hF, 32'hFFFFFFFF);
        wr_reg(REG_CTRL, 32'h0);
        rd_reg(REG_CTRL);
        `CHK(d[0], 1'b0)
        wr_reg(REG_CTRL, 32'h1);
        wait_state(7'h02, 60);
        `CHK(disp.func, FUNC_FIRST)
        `CHK({disp.func_flash, disp.t1_ind}, 2'b11)
        push(B_OK, 2);
        sc = SC_S;
        `CHK({disp.scale_flash, disp.scale}, {1'b1, sc})
        for (f = 0; f < 7; f++) begin
            sc = nsc(sc);
            push(B_MODE, 2);
            `CHK(disp.scale, sc)
        end
        push(B_OK, 2);
        `CHK(disp.digit_flash, 1'b1)
        repeat (60) push(B_PLUS, 2);
        `CHK(disp.value, 14'h003B)
        push(B_MINUS, 2);
        `CHK(disp.value, 14'h003A)
        push(B_OK, 2);
        `CHK(disp.digit_flash, 1'b0)
        `CHK({relay, led}, 2'b11)
        `CHK({disp.func_flash, disp.dp_flash, disp.clock_sym}, 3'h7)
        push(B_MODE, 215);
        rd_reg(REG_STAT);
        `CHK(d[6:0], 7'h02)
        `CHK({relay, led}, 2'b00)
        `CHK(disp.func, 4'h1)
        m = 5 + int'(seed % 32'd10);
        for (f = 2; f <= m; f++) begin
            push(B_PLUS, 2);
            `CHK(disp.func, 4'(f))
            `CHK({disp.t2_ind, disp.start_sym}, {T2_MASK[f], START_MASK[f]})
        end
        for (f = m - 1; f >= 4; f--) begin
            push(B_MINUS, 2);
            `CHK(disp.func, 4'(f))
        end
        push(B_OK, 2);
        `CHK(disp.scale, SC_S)
        push(B_OK, 2);
        push(B_OK, 2);
        `CHK({disp.t2_ind, disp.value}, {1'b1, 14'h0001})
        push(B_OK, 2);
        `CHK({relay, disp.t1_ind, disp.t2_ind}, 3'b110)
        for (cnt = 0; relay === 1'b1 && cnt < 100; cnt++) @(posedge mclk_in);
        `CHK(cnt inside {[24:44]}, 1'b1)
        for (f = 0; f < 60; f++) begin
            rd_reg(REG_STAT);
            if (d[8] === 1'b0) break;
        end
        `CHK(f < 60, 1'b1)
        cyc(2);
        `CHK({disp.t1_ind, disp.t2_ind, disp.clock_sym}, 3'b110)
        `CHK({disp.func, disp.func_flash}, 5'h08)
        @(posedge mclk_in);
        mrst <= 1'b1;
        @(posedge mclk_in);
        mrst <= 1'b0;
        wait_state(7'h20, 60);
        `CHK(disp.func, 4'h4)
        push(B_OK, 215);
        rd_reg(REG_STAT);
        `CHK(d[6:0], 7'h40)
        `CHK({disp.hundredfold_scale_indicator_ind, disp.value}, 15'h0000)
        wait_state(7'h20, 300);
        `CHK(cnt inside {[165:205]}, 1'b1)
        push(B_OK, 215);
        push(B_OK, 215);
        rd_reg(REG_STAT);
        `CHK(d[6:0], 7'h20)
        rd_reg(REG_HOURS);
        `CHK(d, 32'h0)
        push(B_MODE, 215);
        repeat (6) push(B_PLUS, 2);
        push(B_OK, 2);
        push(B_OK, 2);
        push(B_OK, 2);
        push(B_MODE, 2);
        `CHK({disp.t2_ind, disp.scale_flash, disp.func}, 6'h3A)
        push(B_OK, 2);
        push(B_PLUS, 2);
        `CHK({disp.t2_ind, disp.value}, {1'b1, 14'h0002})
        push(B_OK, 2);
        cyc(100);
        `CHK({disp.t1_ind, disp.t2_ind, disp.start_sym}, 3'b101)
        `CHK(disp.value, 14'h0001)
        cyc(150);
        `CHK({disp.t1_ind, disp.t2_ind}, 2'b01)
        `CHK(disp.value, 14'h0002)
        @(posedge mclk_in);
        start <= 1'b0;
        @(posedge mclk_in);
        start <= 1'b1;
        cyc(4);
        `CHK({relay, disp.start_lvl, disp.clock_sym}, 3'b111)
        final_report();
    end
endmodule : tb_multifunction_relay_timer_ui
`default_nettype wire
